// file: crmh_pkg.sv
package crmh_pkg;
    // Token stream: 8-bit payload plus control-token flag
    localparam int TOK_W = 8;
    localparam logic [7:0] CT_WRITE = 8'hc0;   // 192
    localparam logic [7:0] CT_READ = 8'hc1;    // 193
    localparam logic [7:0] CT_END = 8'h01;
    localparam logic [7:0] CT_ACK = 8'h03;
    localparam logic [7:0] CT_NACK = 8'h04;
    localparam logic [7:0] NOREPLY_LSB = 8'hff;
    // Field lengths in bytes
    localparam logic [2:0] RET_BYTES = 3'h3;
    localparam logic [2:0] REG_BYTES = 3'h2;
    localparam logic [2:0] DATA_BYTES = 3'h4;
    // Register file of the device end
    localparam int NREGS = 8;
    localparam logic [7:0] REG_WRITABLE = 8'h7f;  // entry 7 is read-only
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [31:0] RO_VALUE = 32'h0000_0001; // arbitrary value
    // Processor-status resource identifier forming
    localparam int PS_SHIFT = 8;
    localparam logic [31:0] PS_RES_TYPE = 32'h0000_000b;
    // Destination address low parts
    localparam logic [15:0] TILE_DEST_LOW = 16'hc20c;
    localparam logic [15:0] NODE_DEST_LOW = 16'hc30c;
endpackage : crmh_pkg

// file: crmh_link_if.sv
`timescale 1ns/10ps
// Two token channels: request (requester to handler) and reply
interface crmh_link_if;
    logic req_valid;
    logic req_ready;
    logic req_ctrl;
    logic [7:0] req_data;
    logic rsp_valid;
    logic rsp_ready;
    logic rsp_ctrl;
    logic [7:0] rsp_data;
    modport handler (
        input req_valid, req_ctrl, req_data, rsp_ready,
        output req_ready, rsp_valid, rsp_ctrl, rsp_data
    );
    modport requester (
        output req_valid, req_ctrl, req_data, rsp_ready,
        input req_ready, rsp_valid, rsp_ctrl, rsp_data
    );
endinterface : crmh_link_if

// file: crmh_handler.sv
`timescale 1ns/10ps
module crmh_handler (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Token link
    crmh_link_if.handler link,
    // Status
    output logic busy_out,
    output logic [23:0] last_return_out
);
    import crmh_pkg::*;

    typedef enum logic [3:0] {
        CRMH_IDLE = 4'h0,
        CRMH_RET = 4'h1,
        CRMH_REG = 4'h2,
        CRMH_DATA = 4'h3,
        CRMH_END = 4'h4,
        CRMH_HEAD = 4'h5,
        CRMH_RDATA = 4'h6,
        CRMH_TAIL = 4'h7,
        CRMH_DROP = 4'h8
    } crmh_state_t;

    crmh_state_t state_reg, state_next;
    logic is_write_reg, is_write_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [23:0] ret_reg, ret_next;
    logic [15:0] regn_reg, regn_next;
    logic [31:0] data_reg, data_next;
    logic ok_reg, ok_next;
    logic [NREGS*32-1:0] regs_reg, regs_next;
    logic [31:0] rd_word;
    logic reg_valid, reg_writable;
    logic req_fire, rsp_fire;

    //----------------------------------------------------------------
    // Register storage
    //----------------------------------------------------------------
    // Indexed read; last entry is a fixed read-only word
    always_comb begin
        reg_valid = (regn_reg < 16'(NREGS));
        reg_writable = reg_valid && REG_WRITABLE[regn_reg[2:0]];
        rd_word = regs_reg[regn_reg[2:0]*32 +: 32];
        if (regn_reg[2:0] == 3'h7) begin
            rd_word = RO_VALUE;
        end
    end

    assign req_fire = link.req_valid && link.req_ready;
    assign rsp_fire = link.rsp_valid && link.rsp_ready;
    // Request side stalls while a reply is going out
    assign link.req_ready = (state_reg <= CRMH_END) ||
                            (state_reg == CRMH_DROP);
    assign busy_out = (state_reg != CRMH_IDLE);
    assign last_return_out = ret_reg;

    //----------------------------------------------------------------
    // Parser and reply sequencer
    //----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        is_write_next = is_write_reg;
        cnt_next = cnt_reg;
        ret_next = ret_reg;
        regn_next = regn_reg;
        data_next = data_reg;
        ok_next = ok_reg;
        regs_next = regs_reg;
        link.rsp_valid = 1'b0;
        link.rsp_ctrl = 1'b1;
        link.rsp_data = CT_END;
        case (state_reg)
            CRMH_IDLE: begin
                if (req_fire && link.req_ctrl &&
                    (link.req_data == CT_WRITE ||
                     link.req_data == CT_READ)) begin
                    is_write_next = (link.req_data == CT_WRITE);
                    cnt_next = RET_BYTES;
                    state_next = CRMH_RET;
                end
            end
            CRMH_RET: begin
                if (req_fire) begin
                    if (link.req_ctrl) begin
                        state_next = CRMH_DROP;
                    end else begin
                        ret_next = {ret_reg[15:0], link.req_data};
                        cnt_next = cnt_reg - 3'h1;
                        if (cnt_reg == 3'h1) begin
                            cnt_next = REG_BYTES;
                            state_next = CRMH_REG;
                        end
                    end
                end
            end
            CRMH_REG: begin
                // register number shifted in high byte first
                if (req_fire) begin
                    if (link.req_ctrl) begin
                        state_next = CRMH_DROP;
                    end else begin
                        regn_next = {regn_reg[7:0], link.req_data};
                        cnt_next = cnt_reg - 3'h1;
                        if (cnt_reg == 3'h1) begin
                            cnt_next = DATA_BYTES;
                            state_next = is_write_reg ? CRMH_DATA
                                                      : CRMH_END;
                        end
                    end
                end
            end
            CRMH_DATA: begin
                if (req_fire) begin
                    if (link.req_ctrl) begin
                        state_next = CRMH_DROP;
                    end else begin
                        data_next = {data_reg[23:0], link.req_data};
                        cnt_next = cnt_reg - 3'h1;
                        if (cnt_reg == 3'h1) begin
                            state_next = CRMH_END;
                        end
                    end
                end
            end
            CRMH_END: begin
                // closing token 1 commits the request
                if (req_fire) begin
                    if (link.req_ctrl && link.req_data == CT_END) begin
                        ok_next = is_write_reg ? reg_writable : reg_valid;
                        if (is_write_reg && reg_writable) begin
                            regs_next[regn_reg[2:0]*32 +: 32] = data_reg;
                        end
                        if (!is_write_reg) begin
                            data_next = rd_word;
                        end
                        cnt_next = DATA_BYTES;
                        state_next = CRMH_HEAD;
                        // all-ones low byte on a write skips the reply
                        if (is_write_reg &&
                            ret_reg[7:0] == NOREPLY_LSB) begin
                            state_next = CRMH_IDLE;
                        end
                    end else begin
                        // Any other closer spoils the whole message
                        state_next = CRMH_DROP;
                    end
                end
            end
            CRMH_HEAD: begin
                link.rsp_valid = 1'b1;
                link.rsp_data = ok_reg ? CT_ACK : CT_NACK;
                if (rsp_fire) begin
                    state_next = (ok_reg && !is_write_reg) ? CRMH_RDATA
                                                           : CRMH_TAIL;
                end
            end
            CRMH_RDATA: begin
                link.rsp_valid = 1'b1;
                link.rsp_ctrl = 1'b0;
                link.rsp_data = data_reg[31:24];
                if (rsp_fire) begin
                    data_next = {data_reg[23:0], 8'h00};
                    cnt_next = cnt_reg - 3'h1;
                    if (cnt_reg == 3'h1) begin
                        state_next = CRMH_TAIL;
                    end
                end
            end
            CRMH_TAIL: begin
                link.rsp_valid = 1'b1;
                if (rsp_fire) begin
                    state_next = CRMH_IDLE;
                end
            end
            CRMH_DROP: begin
                // Malformed message: discard up to its end token
                if (req_fire && link.req_ctrl &&
                    link.req_data == CT_END) begin
                    state_next = CRMH_IDLE;
                end
            end
            default: begin
                state_next = CRMH_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= CRMH_IDLE;
            is_write_reg <= 1'b0;
            cnt_reg <= 3'h0;
            ret_reg <= 24'h000000;
            regn_reg <= 16'h0000;
            data_reg <= 32'h0000_0000;
            ok_reg <= 1'b0;
            regs_reg <= {NREGS{REG_RESET}};
        end else begin
            state_reg <= state_next;
            is_write_reg <= is_write_next;
            cnt_reg <= cnt_next;
            ret_reg <= ret_next;
            regn_reg <= regn_next;
            data_reg <= data_next;
            ok_reg <= ok_next;
            regs_reg <= regs_next;
        end
    end
endmodule : crmh_handler

// file: crmh_requester.sv
`timescale 1ns/10ps
module crmh_requester (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // User command
    input wire logic start_in,
    input wire logic write_in,
    input wire logic [23:0] return_in,
    input wire logic [15:0] reg_num_in,
    input wire logic [31:0] wdata_in,
    input wire logic [15:0] node_id_in,
    input wire logic node_cfg_in,
    // User result
    output logic busy_out,
    output logic done_out,
    output logic ok_out,
    output logic [31:0] rdata_out,
    output logic [31:0] dest_out,
    output logic [31:0] ps_res_id_out,
    // Token link
    crmh_link_if.requester link
);
    import crmh_pkg::*;

    typedef enum logic [2:0] {
        CRMR_IDLE = 3'h0,
        CRMR_SEND = 3'h1,
        CRMR_WAIT = 3'h2,
        CRMR_DATA = 3'h3,
        CRMR_TAIL = 3'h4
    } crmr_state_t;

    crmr_state_t state_reg, state_next;
    logic [79:0] msg_reg, msg_next;
    logic [3:0] left_reg, left_next;
    logic [1:0] dcnt_reg, dcnt_next;
    logic silent_reg, silent_next;
    logic done_reg, done_next;
    logic ok_reg, ok_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] dest_reg, dest_next;
    logic [31:0] ps_reg, ps_next;
    logic wr_kind_reg, wr_kind_next;
    logic last_tok;

    assign busy_out = (state_reg != CRMR_IDLE);
    assign done_out = done_reg;
    assign ok_out = ok_reg;
    assign rdata_out = rdata_reg;
    assign dest_out = dest_reg;
    assign ps_res_id_out = ps_reg;
    assign link.rsp_ready = (state_reg >= CRMR_WAIT);
    assign link.req_valid = (state_reg == CRMR_SEND);
    assign link.req_data = msg_reg[79:72];
    // First and last tokens are control tokens
    assign last_tok = (left_reg == 4'h1);

    //----------------------------------------------------------------
    // Message builder and reply collector
    //----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        msg_next = msg_reg;
        left_next = left_reg;
        dcnt_next = dcnt_reg;
        silent_next = silent_reg;
        wr_kind_next = wr_kind_reg;
        done_next = 1'b0;
        ok_next = ok_reg;
        rdata_next = rdata_reg;
        dest_next = dest_reg;
        ps_next = ps_reg;
        link.req_ctrl = 1'b0;
        case (state_reg)
            CRMR_IDLE: begin
                if (start_in) begin
                    dest_next = {node_id_in, node_cfg_in ? NODE_DEST_LOW
                                                         : TILE_DEST_LOW};
                    ps_next = ({16'h0000, reg_num_in} << PS_SHIFT) |
                              PS_RES_TYPE;
                    if (write_in) begin
                        msg_next = {CT_WRITE, return_in, reg_num_in,
                                    wdata_in};
                        left_next = 4'hb;
                    end else begin
                        msg_next = {CT_READ, return_in, reg_num_in,
                                    32'h0000_0000};
                        left_next = 4'h7;
                    end
                    wr_kind_next = write_in;
                    silent_next = write_in &&
                                  (return_in[7:0] == NOREPLY_LSB);
                    state_next = CRMR_SEND;
                end
            end
            CRMR_SEND: begin
                // Opener is the first slot, closer the last
                link.req_ctrl = last_tok ||
                    (left_reg == (wr_kind_reg ? 4'hb : 4'h7));
                if (link.req_ready) begin
                    msg_next = {msg_reg[71:0], 8'h00};
                    left_next = left_reg - 4'h1;
                    // Closing token slot
                    if (left_reg == 4'h2) begin
                        msg_next = {CT_END, 72'h0};
                    end
                    if (last_tok) begin
                        state_next = silent_reg ? CRMR_IDLE : CRMR_WAIT;
                        done_next = silent_reg;
                        ok_next = silent_reg;
                    end
                end
            end
            CRMR_WAIT: begin
                if (link.rsp_valid && link.rsp_ctrl) begin
                    ok_next = (link.rsp_data == CT_ACK);
                    dcnt_next = 2'h0;
                    state_next = (link.rsp_data == CT_ACK && !wr_kind_reg)
                                 ? CRMR_DATA : CRMR_TAIL;
                end
            end
            CRMR_DATA: begin
                if (link.rsp_valid) begin
                    rdata_next = {rdata_reg[23:0], link.rsp_data};
                    dcnt_next = dcnt_reg + 2'h1;
                    if (dcnt_reg == 2'h3) begin
                        state_next = CRMR_TAIL;
                    end
                end
            end
            CRMR_TAIL: begin
                if (link.rsp_valid && link.rsp_ctrl &&
                    link.rsp_data == CT_END) begin
                    done_next = 1'b1;
                    state_next = CRMR_IDLE;
                end
            end
            default: begin
                state_next = CRMR_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= CRMR_IDLE;
            msg_reg <= 80'h0;
            left_reg <= 4'h0;
            dcnt_reg <= 2'h0;
            silent_reg <= 1'b0;
            wr_kind_reg <= 1'b0;
            done_reg <= 1'b0;
            ok_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            dest_reg <= 32'h0000_0000;
            ps_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            msg_reg <= msg_next;
            left_reg <= left_next;
            dcnt_reg <= dcnt_next;
            silent_reg <= silent_next;
            wr_kind_reg <= wr_kind_next;
            done_reg <= done_next;
            ok_reg <= ok_next;
            rdata_reg <= rdata_next;
            dest_reg <= dest_next;
            ps_reg <= ps_next;
        end
    end
endmodule : crmh_requester

// file: crmh_link_monitor.sv
`timescale 1ns/10ps
// ----------------------------------------
// Link protocol checker
// ----------------------------------------
module crmh_link_monitor (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Request channel
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_ctrl,
    input wire logic [7:0] req_data,
    // Reply channel
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic rsp_ctrl,
    input wire logic [7:0] rsp_data
);
    import crmh_pkg::*;
    logic [3:0] cnt_reg;
    logic wr_reg;
    logic act_reg;
    logic hi_reg;
    logic [7:0] ret_lo_reg;
    logic [7:0] reg_lo_reg;
    logic [7:0] head_reg;
    logic [2:0] idx_reg;
    logic req_take;
    logic rsp_take;
    logic [3:0] last_idx;
    logic close_ok;
    logic bad;
    // Closer position depends on the opener, so it is tracked here
    assign req_take = req_valid && req_ready;
    assign rsp_take = rsp_valid && rsp_ready;
    assign last_idx = wr_reg ? 4'ha : 4'h6;
    assign close_ok = req_take && req_ctrl && req_data == CT_END
        && act_reg && cnt_reg == last_idx;
    assign bad = hi_reg || reg_lo_reg >= 8'h08
        || (wr_reg && reg_lo_reg == 8'h07);
    // Message and reply position trackers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= 4'h0;
            wr_reg <= 1'b0;
            act_reg <= 1'b0;
            hi_reg <= 1'b0;
            ret_lo_reg <= 8'h00;
            reg_lo_reg <= 8'h00;
            head_reg <= 8'h00;
            idx_reg <= 3'h0;
        end else begin
            if (req_take && req_ctrl
                && (req_data == CT_WRITE || req_data == CT_READ)) begin
                cnt_reg <= 4'h1;
                wr_reg <= req_data == CT_WRITE;
                act_reg <= 1'b1;
            end else if (req_take && act_reg) begin
                cnt_reg <= cnt_reg + 4'h1;
                act_reg <= !req_ctrl;
                if (cnt_reg == 4'h3) ret_lo_reg <= req_data;
                if (cnt_reg == 4'h4) hi_reg <= req_data != 8'h00;
                if (cnt_reg == 4'h5) reg_lo_reg <= req_data;
            end
            if (rsp_take) begin
                idx_reg <= (rsp_ctrl && rsp_data == CT_END) ? 3'h0
                    : idx_reg + 3'h1;
                if (idx_reg == 3'h0) head_reg <= rsp_data;
            end
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    a_reply_after_close: assert property (
        close_ok && !(wr_reg && ret_lo_reg == NOREPLY_LSB)
        |=> rsp_valid && rsp_ctrl) else $error("no reply after closer");
    a_silent_write: assert property (
        close_ok && wr_reg && ret_lo_reg == NOREPLY_LSB
        |=> (!rsp_valid) [*6]) else $error("reply to silent write");
    a_head_code: assert property (
        rsp_valid && idx_reg == 3'h0
        |-> rsp_ctrl && rsp_data == (bad ? CT_NACK : CT_ACK))
        else $error("wrong reply head");
    a_nack_len: assert property (
        rsp_valid && idx_reg == 3'h1 && head_reg == CT_NACK
        |-> rsp_ctrl && rsp_data == CT_END) else $error("bad nack tail");
    a_write_ack_len: assert property (
        rsp_valid && idx_reg == 3'h1 && head_reg == CT_ACK && wr_reg
        |-> rsp_ctrl && rsp_data == CT_END) else $error("bad write ack");
    a_read_data_plain: assert property (
        rsp_valid && idx_reg != 3'h0 && idx_reg < 3'h5
        && head_reg == CT_ACK && !wr_reg |-> !rsp_ctrl)
        else $error("control token in read data");
    a_read_end: assert property (
        rsp_valid && idx_reg == 3'h5 |-> rsp_ctrl && rsp_data == CT_END)
        else $error("read reply not closed");
    a_reply_no_gap: assert property (
        rsp_take && !(rsp_ctrl && rsp_data == CT_END) |-> ##[1:4] rsp_valid)
        else $error("reply stalls");
    a_req_closer: assert property (
        req_valid && act_reg && cnt_reg == last_idx
        |-> req_ctrl && req_data == CT_END) else $error("closer misplaced");
    a_req_fields_plain: assert property (
        req_valid && act_reg && cnt_reg != 4'h0 && cnt_reg < last_idx
        |-> !req_ctrl) else $error("control token in request field");
endmodule : crmh_link_monitor

// file: tb_config_register_message_handler.sv
`timescale 1ns/10ps
module tb_config_register_message_handler;
    import crmh_pkg::*;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic start_in = 1'b0;
    logic write_in = 1'b0;
    logic [23:0] return_in = 24'h0;
    logic [15:0] reg_num_in = 16'h0;
    logic [31:0] wdata_in = 32'h0;
    logic [15:0] node_id_in = 16'h0;
    logic node_cfg_in = 1'b0;
    logic busy_out;
    logic done_out;
    logic ok_out;
    logic [31:0] rdata_out;
    logic [31:0] dest_out;
    logic [31:0] ps_res_id_out;
    logic [23:0] last_ret;
    int err_count = 0;
    int comparisons = 0;
    int seed = 45;
    int cycles = 0;
    logic [31:0] model [8];
    logic [8:0] req_q [$];
    logic [8:0] rsp_q [$];
    logic [8:0] rsp2_q [$];
    logic [121:0] res_q [$];
    logic [121:0] e;
    logic [31:0] rd_got;
    logic [8:0] req_tok, rsp_tok, rsp2_tok;
    // Malformed write (read opener in data field), then a good read of 7
    localparam logic [8:0] MSG2 [15] = '{9'h1c0, 9'h000, 9'h000, 9'h001,
        9'h000, 9'h001, 9'h1c1, 9'h101, 9'h1c1, 9'h000, 9'h000, 9'h001,
        9'h000, 9'h007, 9'h101};
    crmh_link_if link ();
    crmh_link_if link2 ();
    assign req_tok = {link.req_ctrl, link.req_data};
    assign rsp_tok = {link.rsp_ctrl, link.rsp_data};
    assign rsp2_tok = {link2.rsp_ctrl, link2.rsp_data};
    crmh_handler i_crmh_handler (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .link(link.handler), .busy_out(), .last_return_out(last_ret));
    crmh_handler i_crmh_handler_2 (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .link(link2.handler), .busy_out(),
        .last_return_out());
    crmh_requester i_crmh_requester (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .start_in(start_in), .write_in(write_in),
        .return_in(return_in), .reg_num_in(reg_num_in),
        .wdata_in(wdata_in), .node_id_in(node_id_in),
        .node_cfg_in(node_cfg_in), .busy_out(busy_out),
        .done_out(done_out), .ok_out(ok_out), .rdata_out(rdata_out),
        .dest_out(dest_out), .ps_res_id_out(ps_res_id_out),
        .link(link.requester));
    crmh_link_monitor u_monitor (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .req_valid(link.req_valid), .req_ready(link.req_ready),
        .req_ctrl(link.req_ctrl), .req_data(link.req_data),
        .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
        .rsp_ctrl(link.rsp_ctrl), .rsp_data(link.rsp_data));
    always #5 clock_in = ~clock_in;
    task automatic results;
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task automatic cmp_tok(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t token %h exp %h", $time, got, exp);
        end
    endtask : cmp_tok
    task automatic cmp_res(input logic [121:0] got, input logic [121:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t result %h exp %h", $time, got, exp);
        end
    endtask : cmp_res
    function automatic logic [23:0] rret();
        // Bit 0 cleared so the low byte never asks for silence
        return 24'($random(seed)) & 24'hff_fffe;
    endfunction : rret
    // ----------------------------------------
    // Requester-side operation with expected tokens and result
    // ----------------------------------------
    task automatic op(input logic wr, input logic [23:0] rt,
                      input logic [15:0] rn, input logic [31:0] wd);
        logic ok;
        logic quiet;
        logic [31:0] rd;
        logic [15:0] nid;
        logic ncfg;
        nid = 16'($random(seed));
        ncfg = 1'($random(seed));
        ok = rn < 16'h8 && !(wr && rn == 16'h7);
        quiet = wr && rt[7:0] == NOREPLY_LSB;
        rd = ok ? model[rn[2:0]] : 32'h0;
        if (ok && wr) model[rn[2:0]] = wd;
        req_q.push_back({1'b1, wr ? CT_WRITE : CT_READ});
        for (int i = 2; i >= 0; i--) req_q.push_back({1'b0, rt[8*i +: 8]});
        for (int i = 1; i >= 0; i--) req_q.push_back({1'b0, rn[8*i +: 8]});
        for (int i = 3; i >= 0 && wr; i--)
            req_q.push_back({1'b0, wd[8*i +: 8]});
        req_q.push_back({1'b1, CT_END});
        if (!quiet) rsp_q.push_back({1'b1, ok ? CT_ACK : CT_NACK});
        for (int i = 3; i >= 0 && ok && !wr; i--)
            rsp_q.push_back({1'b0, rd[8*i +: 8]});
        if (!quiet) rsp_q.push_back({1'b1, CT_END});
        res_q.push_back({wr, ok, rd, nid, ncfg ? NODE_DEST_LOW : TILE_DEST_LOW,
            ({16'h0, rn} << PS_SHIFT) | PS_RES_TYPE, rt});
        @(negedge clock_in);
        {write_in, return_in, reg_num_in, wdata_in} = {wr, rt, rn, wd};
        {node_id_in, node_cfg_in} = {nid, ncfg};
        start_in = 1'b1;
        @(negedge clock_in);
        start_in = 1'b0;
        while (done_out !== 1'b1) @(negedge clock_in);
    endtask : op
    task automatic put2(input logic [8:0] t);
        @(negedge clock_in);
        link2.req_valid = 1'b1;
        {link2.req_ctrl, link2.req_data} = t;
        @(posedge clock_in);
        while (link2.req_ready !== 1'b1) @(posedge clock_in);
    endtask : put2
    // Watcher: every token except link2 requests, and every result, against the oldest note
    always @(posedge clock_in) begin
        if (rst_n_in) begin
            cycles++;
            if (link.req_valid && link.req_ready)
                cmp_tok(req_tok, req_q.pop_front());
            if (link.rsp_valid && link.rsp_ready)
                cmp_tok(rsp_tok, rsp_q.pop_front());
            if (link2.rsp_valid && link2.rsp_ready)
                cmp_tok(rsp2_tok, rsp2_q.pop_front());
            if (done_out === 1'b1) begin
                e = res_q.pop_front();
                // Read data only carries meaning after a good read
                rd_got = (e[121] || !e[120]) ? e[119:88] : rdata_out;
                cmp_res({e[121], ok_out, rd_got, dest_out,
                    ps_res_id_out, last_ret}, e);
            end
            if (cycles == 20000) begin
                err_count++;
                results();
            end
        end
    end
    initial begin
        logic [23:0] rt;
        logic [15:0] r;
        logic [31:0] d;
        {link2.req_valid, link2.req_ctrl, link2.req_data} = 10'h0;
        link2.rsp_ready = 1'b1;
        foreach (model[i]) model[i] = (i == 7) ? RO_VALUE : REG_RESET;
        repeat (6) @(posedge clock_in);
        @(negedge clock_in);
        rst_n_in = 1'b1;
        // Reset contents, then numbers out of range or read-only
        for (int i = 0; i < 9; i++) op(1'b0, rret(), 16'(i), 32'h0);
        op(1'b0, rret(), 16'h0107, 32'h0);
        op(1'b1, rret(), 16'h0007, 32'h1234_5678);
        op(1'b1, rret(), 16'h0008, 32'hffff_ffff);
        op(1'b0, rret(), 16'h0007, 32'h0);
        // Random writes with immediate read-back
        repeat (10) begin
            r = 16'({$random(seed)} % 7);
            d = $random(seed);
            op(1'b1, rret(), r, d);
            op(1'b0, rret(), r, 32'h0);
        end
        // Silent write straight into a read; reads never go silent
        rt = rret();
        op(1'b1, {rt[23:8], NOREPLY_LSB}, 16'h0003, 32'ha5a5_5a5a);
        op(1'b0, {rt[23:8], NOREPLY_LSB}, 16'h0003, 32'h0);
        // Broken message must be dropped without reply
        rsp2_q = '{9'h103, 9'h000, 9'h000, 9'h000, 9'h001, 9'h101};
        foreach (MSG2[i]) put2(MSG2[i]);
        @(negedge clock_in);
        link2.req_valid = 1'b0;
        link2.req_data = ~link2.req_data;
        while (rsp2_q.size() + rsp_q.size() + req_q.size() != 0)
            @(negedge clock_in);
        repeat (2) @(negedge clock_in);
        if (res_q.size() != 0) begin
            err_count++;
            $display("MISMATCH %0t results left over", $time);
        end
        results();
    end
endmodule : tb_config_register_message_handler
